// ===== verilog/dram_config_timing_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dram_config_timing_regs #(
  parameter int CHIPS = 4,
  parameter bit HAS_SELF_REFRESH = 1'b1,
  parameter bit HAS_FORCED_CLOSE = 1'b1,
  parameter logic [2:0] MEM_TYPE = 3'h1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire dram_cfg_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic [1:0] ctrl_state,
  input wire logic [7:0] read_id,
  input wire dram_cfg_pkg::sched_cmd_t cmd,
  input wire logic cmd_fifo_empty,
  input wire logic access_active,
  input wire logic [15:0] col_addr,
  input wire logic autoclose_req,
  output dram_cfg_pkg::dram_cfg_t cfg,
  output dram_cfg_pkg::timing_ok_t timing_ok,
  output logic [3:0] refresh_req,
  output logic [3:0] qos_prio,
  output logic [15:0] mem_addr,
  output logic cke,
  output logic mem_clk_en,
  output logic access_allowed
);
  import dram_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // access gating
  // ----------------------------------------------------------------------
  logic allowed;
  logic wr_en;
  logic rd_setup;

  assign allowed = (ctrl_state == ST_CONFIG) || (ctrl_state == ST_LOW_POWER);
  assign access_allowed = allowed;
  assign pready = 1'b1;
  assign wr_en = apb_req.sel && apb_req.enable && apb_req.write && allowed;
  assign rd_setup = apb_req.sel && !apb_req.enable && !apb_req.write;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic hit_state;
  logic hit_cfg;
  logic hit_refp;
  logic hit_casl;
  logic hit_dqss;
  logic hit_mrd;
  logic hit_ras;
  logic hit_rc;
  logic hit_rcd;
  logic hit_rfc;
  logic hit_rp;
  logic hit_rrd;

  assign hit_state = (apb_req.addr == STATE_OFS);
  assign hit_cfg = (apb_req.addr == CFG_OFS);
  assign hit_refp = (apb_req.addr == REFP_OFS);
  assign hit_casl = (apb_req.addr == CASL_OFS);
  assign hit_dqss = (apb_req.addr == DQSS_OFS);
  assign hit_mrd = (apb_req.addr == MRD_OFS);
  assign hit_ras = (apb_req.addr == RAS_OFS);
  assign hit_rc = (apb_req.addr == RC_OFS);
  assign hit_rcd = (apb_req.addr == RCD_OFS);
  assign hit_rfc = (apb_req.addr == RFC_OFS);
  assign hit_rp = (apb_req.addr == RP_OFS);
  assign hit_rrd = (apb_req.addr == RRD_OFS);

  // ----------------------------------------------------------------------
  // stored registers
  // ----------------------------------------------------------------------
  logic [31:0] cfg_word_reg;
  logic [14:0] refresh_interval_reg;
  logic [3:0] column_access_latency_reg;
  logic [1:0] write_strobe_delay_reg;
  logic [6:0] mode_set_time_reg;
  logic [3:0] act_to_pre_min_reg;
  logic [3:0] act_to_act_same_bank_reg;
  logic [5:0] act_to_rdwr_min_reg;
  logic [9:0] refresh_cmd_time_reg;
  logic [5:0] pre_to_act_min_reg;
  logic [3:0] act_to_act_other_bank_reg;

  // unbuilt optional features keep no flops, so they read zero
  logic [31:0] cfg_mask;
  logic [31:0] cfg_word_next;
  logic half_allowed;
  logic [3:0] cas_next;

  assign cfg_mask = CFG_BASE_MASK | (HAS_FORCED_CLOSE ? CFG_FORCE_MASK : 32'h0)
                    | (HAS_SELF_REFRESH ? CFG_SELF_MASK : 32'h0);
  assign cfg_word_next = apb_req.wdata & cfg_mask;
  assign half_allowed = (MEM_TYPE != MEM_SDR) && (MEM_TYPE != MEM_MOBILE_DDR);
  assign cas_next = {apb_req.wdata[3:1], apb_req.wdata[CAS_HALF_BIT] & half_allowed};

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_word_reg <= CFG_RST & (CFG_BASE_MASK | (HAS_FORCED_CLOSE ? CFG_FORCE_MASK : 32'h0)
                      | (HAS_SELF_REFRESH ? CFG_SELF_MASK : 32'h0));
      refresh_interval_reg <= REFP_RST[14:0];
      column_access_latency_reg <= CASL_RST[3:0];
      write_strobe_delay_reg <= DQSS_RST[1:0];
      mode_set_time_reg <= MRD_RST[6:0];
      act_to_pre_min_reg <= RAS_RST[3:0];
      act_to_act_same_bank_reg <= RC_RST[3:0];
      act_to_rdwr_min_reg <= RCD_RST[5:0];
      refresh_cmd_time_reg <= RFC_RST[9:0];
      pre_to_act_min_reg <= RP_RST[5:0];
      act_to_act_other_bank_reg <= RRD_RST[3:0];
    end
    else if (wr_en)
    begin
      // upper bits are never stored, so they read back as zero
      if (hit_cfg)
        cfg_word_reg <= cfg_word_next;
      if (hit_refp)
        refresh_interval_reg <= apb_req.wdata[14:0];
      if (hit_casl)
        column_access_latency_reg <= cas_next;
      if (hit_dqss)
        write_strobe_delay_reg <= apb_req.wdata[1:0];
      if (hit_mrd)
        mode_set_time_reg <= apb_req.wdata[6:0];
      if (hit_ras)
        act_to_pre_min_reg <= apb_req.wdata[3:0];
      if (hit_rc)
        act_to_act_same_bank_reg <= apb_req.wdata[3:0];
      if (hit_rcd)
        act_to_rdwr_min_reg <= apb_req.wdata[5:0];
      if (hit_rfc)
        refresh_cmd_time_reg <= apb_req.wdata[9:0];
      if (hit_rp)
        pre_to_act_min_reg <= apb_req.wdata[5:0];
      if (hit_rrd)
        act_to_act_other_bank_reg <= apb_req.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;
  logic [31:0] rd_gated;
  logic [31:0] prdata_reg;

  assign rd_word = ({32{hit_cfg}} & cfg_word_reg)
                   | ({32{hit_refp}} & {17'h0, refresh_interval_reg})
                   | ({32{hit_casl}} & {28'h0, column_access_latency_reg})
                   | ({32{hit_dqss}} & {30'h0, write_strobe_delay_reg})
                   | ({32{hit_mrd}} & {25'h0, mode_set_time_reg})
                   | ({32{hit_ras}} & {28'h0, act_to_pre_min_reg})
                   | ({32{hit_rc}} & {28'h0, act_to_act_same_bank_reg})
                   | ({32{hit_rcd}} & {26'h0, act_to_rdwr_min_reg})
                   | ({32{hit_rfc}} & {22'h0, refresh_cmd_time_reg})
                   | ({32{hit_rp}} & {26'h0, pre_to_act_min_reg})
                   | ({32{hit_rrd}} & {28'h0, act_to_act_other_bank_reg});
  // the state word stays readable so software can see when access opens
  assign rd_gated = (allowed ? rd_word : 32'h0)
                    | ({32{hit_state}} & {30'h0, ctrl_state});
  assign prdata = prdata_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata_reg <= 32'h0;
    else if (rd_setup)
      prdata_reg <= rd_gated;
  end

  // ----------------------------------------------------------------------
  // decoded configuration for the scheduler
  // ----------------------------------------------------------------------
  logic [2:0] burst_code;
  logic [2:0] row_code;
  logic [2:0] col_code;

  assign burst_code = cfg_word_reg[17:15] > BURST_CODE_MAX ? BURST_CODE_MAX : cfg_word_reg[17:15];
  assign row_code = (cfg_word_reg[5:3] > ROW_CODE_MAX) ? ROW_CODE_MAX : cfg_word_reg[5:3];
  assign col_code = (cfg_word_reg[2:0] > COL_CODE_MAX) ? COL_CODE_MAX : cfg_word_reg[2:0];

  assign cfg.auto_self_refresh_en = cfg_word_reg[SELF_REFRESH_BIT];
  assign cfg.forced_close_timeout = cfg_word_reg[30:24];
  assign cfg.forced_close_en = cfg_word_reg[FORCE_EN_BIT];
  assign cfg.burst_beats = 5'(5'h01 << burst_code);
  assign cfg.autoclose_bit_position = cfg_word_reg[AUTOCLOSE_SEL_BIT] ? AUTOCLOSE_ADDR_LO
                                      : AUTOCLOSE_ADDR_HI;
  assign cfg.row_width = ROW_BASE + {2'h0, row_code};
  assign cfg.col_width = COL_BASE + {1'h0, col_code};
  assign cfg.cas_cycles = column_access_latency_reg[3:1];
  assign cfg.cas_half = column_access_latency_reg[CAS_HALF_BIT];
  assign cfg.write_strobe_delay = write_strobe_delay_reg;
  assign cfg.act_to_rdwr_sys_cycles = 4'(act_to_rdwr_min_reg[5:3]) + 4'(SCHED_OFFSET);
  assign cfg.refresh_sys_cycles = {1'h0, refresh_cmd_time_reg[9:5]} + 6'(SCHED_OFFSET);
  assign cfg.pre_to_act_sys_cycles = {1'h0, pre_to_act_min_reg[5:3]} + 4'(SCHED_OFFSET);

  // ----------------------------------------------------------------------
  // refresh chip selection and pacing
  // ----------------------------------------------------------------------
  localparam logic [1:0] CHIP_LIMIT = 2'(CHIPS - 1);
  logic [1:0] chip_field;
  logic [1:0] chip_top;
  logic [3:0] chip_mask;
  logic refresh_enable;

  assign chip_field = cfg_word_reg[22:21];
  assign chip_top = (chip_field > CHIP_LIMIT) ? CHIP_LIMIT : chip_field;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chip
      assign chip_mask[gi] = (2'(gi) <= chip_top);
    end
  endgenerate

  // no refreshes while the controller sits in Config
  assign refresh_enable = (ctrl_state != ST_CONFIG);

  refresh_pacer #(.W(15)) u_refresh (
    .mclk(mclk),
    .rst(rst),
    .enable(refresh_enable),
    .period(refresh_interval_reg),
    .chip_mask(chip_mask),
    .refresh_req(refresh_req)
  );

  // ----------------------------------------------------------------------
  // command gap timers
  // ----------------------------------------------------------------------
  logic ras_done;
  logic rc_done;
  logic rrd_done;
  logic rcd_done;
  logic rfc_done;
  logic rp_done;
  logic mrd_done;
  logic common_ok;

  gap_timer #(.W(4)) u_ras (.mclk(mclk), .rst(rst), .start(cmd.act),
    .gap(act_to_pre_min_reg), .done(ras_done));
  gap_timer #(.W(4)) u_rc (.mclk(mclk), .rst(rst), .start(cmd.act),
    .gap(act_to_act_same_bank_reg), .done(rc_done));
  gap_timer #(.W(4)) u_rrd (.mclk(mclk), .rst(rst), .start(cmd.act),
    .gap(act_to_act_other_bank_reg), .done(rrd_done));
  gap_timer #(.W(3)) u_rcd (.mclk(mclk), .rst(rst), .start(cmd.act),
    .gap(act_to_rdwr_min_reg[2:0]), .done(rcd_done));
  gap_timer #(.W(5)) u_rfc (.mclk(mclk), .rst(rst), .start(cmd.refresh),
    .gap(refresh_cmd_time_reg[4:0]), .done(rfc_done));
  gap_timer #(.W(3)) u_rp (.mclk(mclk), .rst(rst), .start(cmd.pre),
    .gap(pre_to_act_min_reg[2:0]), .done(rp_done));
  gap_timer #(.W(7)) u_mrd (.mclk(mclk), .rst(rst), .start(cmd.mode_set),
    .gap(mode_set_time_reg), .done(mrd_done));

  // one tracked bank: the same-bank gap applies to the last bank opened
  assign common_ok = rfc_done && mrd_done;
  assign timing_ok.act_same_ok = rc_done && rp_done && common_ok;
  assign timing_ok.act_other_ok = rrd_done && rp_done && common_ok;
  assign timing_ok.pre_ok = ras_done && common_ok;
  assign timing_ok.col_ok = rcd_done && common_ok;
  assign timing_ok.cmd_ok = common_ok;

  // ----------------------------------------------------------------------
  // read priority, autoclose address, clock stop and power-down
  // ----------------------------------------------------------------------
  logic [2:0] prio_code;
  logic [7:0] id_shifted;
  logic [3:0] qos_prio_reg;
  logic [15:0] autoclose_flag;
  logic [15:0] mem_addr_reg;
  logic mem_clk_en_reg;
  logic [5:0] idle_reg;
  logic [5:0] idle_next;
  logic idle_reached;
  logic cke_reg;

  assign prio_code = (cfg_word_reg[20:18] > PRIO_CODE_MAX) ? PRIO_CODE_MAX : cfg_word_reg[20:18];
  assign id_shifted = read_id >> prio_code;
  assign autoclose_flag = 16'(autoclose_req) << cfg.autoclose_bit_position;
  assign idle_reached = (idle_reg == cfg_word_reg[12:7]);
  assign idle_next = (!cfg_word_reg[PDOWN_EN_BIT] || !cmd_fifo_empty) ? 6'h0
                     : (idle_reached ? idle_reg : idle_reg + 6'h1);
  assign qos_prio = qos_prio_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_clk_en = mem_clk_en_reg;
  assign cke = cke_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      qos_prio_reg <= 4'h0;
      mem_addr_reg <= 16'h0;
      mem_clk_en_reg <= 1'b1;
      idle_reg <= 6'h0;
      cke_reg <= 1'b1;
    end
    else
    begin
      qos_prio_reg <= id_shifted[3:0];
      mem_addr_reg <= col_addr | autoclose_flag;
      mem_clk_en_reg <= !(cfg_word_reg[CLK_STOP_BIT] && !access_active);
      idle_reg <= idle_next;
      // cke returns as soon as work arrives or the feature is turned off
      cke_reg <= !(cfg_word_reg[PDOWN_EN_BIT] && cmd_fifo_empty && idle_reached);
    end
  end
endmodule // dram_config_timing_regs
`default_nettype wire

// ===== common/dram_cfg_pkg.sv
package dram_cfg_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] STATE_OFS = 12'h000;
  localparam logic [11:0] CFG_OFS = 12'h00c;
  localparam logic [11:0] REFP_OFS = 12'h010;
  localparam logic [11:0] CASL_OFS = 12'h014;
  localparam logic [11:0] DQSS_OFS = 12'h018;
  localparam logic [11:0] MRD_OFS = 12'h01c;
  localparam logic [11:0] RAS_OFS = 12'h020;
  localparam logic [11:0] RC_OFS = 12'h024;
  localparam logic [11:0] RCD_OFS = 12'h028;
  localparam logic [11:0] RFC_OFS = 12'h02c;
  localparam logic [11:0] RP_OFS = 12'h030;
  localparam logic [11:0] RRD_OFS = 12'h034;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [31:0] CFG_RST = 32'h0001_0020;
  localparam logic [31:0] REFP_RST = 32'h0000_0a60;
  localparam logic [31:0] CASL_RST = 32'h0000_0006;
  localparam logic [31:0] DQSS_RST = 32'h0000_0001;
  localparam logic [31:0] MRD_RST = 32'h0000_0002;
  localparam logic [31:0] RAS_RST = 32'h0000_0007;
  localparam logic [31:0] RC_RST = 32'h0000_000b;
  localparam logic [31:0] RCD_RST = 32'h0000_001d;
  localparam logic [31:0] RFC_RST = 32'h0000_0212;
  localparam logic [31:0] RP_RST = 32'h0000_001d;
  localparam logic [31:0] RRD_RST = 32'h0000_0002;

  // ----------------------------------------------------------------------
  // configuration word fields and writable masks
  // ----------------------------------------------------------------------
  localparam int SELF_REFRESH_BIT = 31;
  localparam int FORCE_EN_BIT = 23;
  localparam int CLK_STOP_BIT = 14;
  localparam int PDOWN_EN_BIT = 13;
  localparam int AUTOCLOSE_SEL_BIT = 6;
  localparam int CAS_HALF_BIT = 0;
  localparam logic [31:0] CFG_BASE_MASK = 32'h007f_ffff;
  localparam logic [31:0] CFG_FORCE_MASK = 32'h7f80_0000;
  localparam logic [31:0] CFG_SELF_MASK = 32'h8000_0000;
  localparam logic [2:0] BURST_CODE_MAX = 3'h4;
  localparam logic [2:0] ROW_CODE_MAX = 3'h5;
  localparam logic [2:0] COL_CODE_MAX = 3'h4;
  localparam logic [2:0] PRIO_CODE_MAX = 3'h4;
  localparam logic [4:0] ROW_BASE = 5'h0b;
  localparam logic [3:0] COL_BASE = 4'h8;
  localparam logic [3:0] AUTOCLOSE_ADDR_LO = 4'h8;
  localparam logic [3:0] AUTOCLOSE_ADDR_HI = 4'ha;
  localparam int SCHED_OFFSET = 3;

  // ----------------------------------------------------------------------
  // controller state codes and memory types
  // ----------------------------------------------------------------------
  localparam logic [1:0] ST_CONFIG = 2'h0;
  localparam logic [1:0] ST_LOW_POWER = 2'h3;
  localparam logic [2:0] MEM_SDR = 3'h0;
  localparam logic [2:0] MEM_MOBILE_DDR = 3'h3;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic act;
    logic pre;
    logic col;
    logic refresh;
    logic mode_set;
  } sched_cmd_t;

  typedef struct packed {
    logic act_same_ok;
    logic act_other_ok;
    logic pre_ok;
    logic col_ok;
    logic cmd_ok;
  } timing_ok_t;

  typedef struct packed {
    logic auto_self_refresh_en;
    logic [6:0] forced_close_timeout;
    logic forced_close_en;
    logic [4:0] burst_beats;
    logic [3:0] autoclose_bit_position;
    logic [4:0] row_width;
    logic [3:0] col_width;
    logic [2:0] cas_cycles;
    logic cas_half;
    logic [1:0] write_strobe_delay;
    logic [3:0] act_to_rdwr_sys_cycles;
    logic [5:0] refresh_sys_cycles;
    logic [3:0] pre_to_act_sys_cycles;
  } dram_cfg_t;

endpackage

// ===== verilog/gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] gap,
  output logic done
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // a new start reloads even while a previous gap is still running
  assign count_next = start ? gap : ((count_reg != '0) ? count_reg - 1'b1 : count_reg);
  assign done = (count_reg == '0);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end
endmodule // gap_timer
`default_nettype wire

// ===== verilog/refresh_pacer.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_pacer #(
  parameter int W = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [W-1:0] period,
  input wire logic [3:0] chip_mask,
  output logic [3:0] refresh_req
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] reload;
  logic [3:0] req_reg;
  logic [3:0] req_next;
  logic expired;

  assign expired = enable && (count_reg == '0);
  // reload one short so that a nonzero period of p gives exactly p cycles between requests; a period of 0 gives a request every cycle
  assign reload = (period == '0) ? '0 : period - 1'b1;
  assign count_next = (!enable || expired) ? reload : count_reg - 1'b1;
  assign req_next = expired ? chip_mask : 4'h0;
  assign refresh_req = req_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= '0;
      req_reg <= 4'h0;
    end
    else
    begin
      count_reg <= count_next;
      req_reg <= req_next;
    end
  end
endmodule // refresh_pacer
`default_nettype wire

// ===== sim/dram_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dram_regs_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire dram_cfg_pkg::apb_req_t apb_req,
  input wire logic [1:0] ctrl_state,
  input wire dram_cfg_pkg::sched_cmd_t cmd,
  input wire logic cmd_fifo_empty,
  input wire logic [15:0] col_addr,
  input wire logic autoclose_req,
  input wire dram_cfg_pkg::dram_cfg_t cfg,
  input wire dram_cfg_pkg::timing_ok_t timing_ok,
  input wire logic [15:0] mem_addr,
  input wire logic cke,
  input wire logic access_allowed
);
  import dram_cfg_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire wr_cyc = apb_req.sel & apb_req.enable & apb_req.write;
  wire st_ok = (ctrl_state == ST_CONFIG) | (ctrl_state == ST_LOW_POWER);
  a_access_gate: assert property (access_allowed == st_ok)
    else $error("access gate wrong");
  a_burst_legal: assert property ($onehot(cfg.burst_beats))
    else $error("burst count illegal");
  a_row_range: assert property (cfg.row_width >= 5'h0b && cfg.row_width <= 5'h10)
    else $error("row width out of range");
  a_col_range: assert property (cfg.col_width >= 4'h8 && cfg.col_width <= 4'hc)
    else $error("column width out of range");
  a_autoclose_pos: assert property (!$past(rst) |-> mem_addr == ($past(col_addr) |
    (16'($past(autoclose_req)) << $past(cfg.autoclose_bit_position)))) else $error("bad mem_addr");
  a_pre_block: assert property (cmd.act |=> !timing_ok.pre_ok)
    else $error("precharge allowed after activate");
  a_refresh_block: assert property (cmd.refresh |=> !timing_ok.cmd_ok)
    else $error("command allowed after refresh");
  a_write_held: assert property (wr_cyc && !st_ok |=> $stable(cfg))
    else $error("write taken in wrong state");
  a_cke_wake: assert property (!cmd_fifo_empty |=> cke)
    else $error("cke low with queued commands");
  c_cfg_write: cover property (wr_cyc && st_ok);
  c_act: cover property (cmd.act);
  c_pdown: cover property ($fell(cke));
endmodule // dram_regs_chk
bind dram_config_timing_regs dram_regs_chk u_chk (.mclk(mclk), .rst(rst), .apb_req(apb_req),
  .ctrl_state(ctrl_state), .cmd(cmd), .cmd_fifo_empty(cmd_fifo_empty), .col_addr(col_addr),
  .autoclose_req(autoclose_req), .cfg(cfg), .timing_ok(timing_ok), .mem_addr(mem_addr),
  .cke(cke), .access_allowed(access_allowed));
`default_nettype wire

// ===== sim/sdram_side.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_side (
  input wire logic mclk,
  input wire logic act_go,
  input wire logic ref_go,
  input wire logic busy,
  output dram_cfg_pkg::sched_cmd_t cmd,
  output logic cmd_fifo_empty,
  output logic access_active
);
  import dram_cfg_pkg::*;
  // the modelled memory is taken to run the burst length and column latency
  // that the controller holds, as if its mode register had been set to match
  // commands leave as one-cycle pulses, the way the scheduler issues them
  always_ff @(posedge mclk) cmd <= '{act_go, 1'b0, 1'b0, ref_go, 1'b0};
  assign cmd_fifo_empty = !busy;
  assign access_active = busy;
endmodule // sdram_side
`default_nettype wire

// ===== sim/dram_config_timing_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_config_timing_regs_tb;
  import dram_cfg_pkg::*;
  logic mclk = 0, rst = 1, act_go = 0, ref_go = 0, busy = 0, autoclose_req = 0;
  logic cke, mem_clk_en, access_allowed, pready, cmd_fifo_empty, access_active;
  logic [1:0] ctrl_state = 0;
  logic [7:0] read_id = 0;
  logic [15:0] col_addr = 0, mem_addr;
  logic [3:0] refresh_req, qos_prio;
  logic [31:0] prdata, s = 32'h8ab2, v[11], q[$];
  apb_req_t req = '0;
  sched_cmd_t cmd;
  dram_cfg_t cfg;
  timing_ok_t timing_ok;
  int n_mismatch = 0, total_checks = 0, n;
  localparam logic [11:0] OFS[11] = '{CFG_OFS, REFP_OFS, CASL_OFS, DQSS_OFS, MRD_OFS,
    RAS_OFS, RC_OFS, RCD_OFS, RFC_OFS, RP_OFS, RRD_OFS};
  localparam logic [31:0] RST[11] = '{CFG_RST, REFP_RST, CASL_RST, DQSS_RST, MRD_RST,
    RAS_RST, RC_RST, RCD_RST, RFC_RST, RP_RST, RRD_RST};
  localparam logic [31:0] MSK[11] = '{32'h0, 32'h7fff, 32'hf, 32'h3, 32'h7f, 32'hf, 32'hf,
    32'h3f, 32'h3ff, 32'h3f, 32'hf};
  dram_config_timing_regs dut (.mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .ctrl_state(ctrl_state), .read_id(read_id), .cmd(cmd),
    .cmd_fifo_empty(cmd_fifo_empty), .access_active(access_active), .col_addr(col_addr),
    .autoclose_req(autoclose_req), .cfg(cfg), .timing_ok(timing_ok), .refresh_req(refresh_req),
    .qos_prio(qos_prio), .mem_addr(mem_addr), .cke(cke), .mem_clk_en(mem_clk_en),
    .access_allowed(access_allowed));
  sdram_side u_side (.mclk(mclk), .act_go(act_go), .ref_go(ref_go), .busy(busy), .cmd(cmd),
    .cmd_fifo_empty(cmd_fifo_empty), .access_active(access_active));
  initial forever #4 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one cycle of idle after each access keeps back-to-back calls from colliding
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    req = '{1'b1, 1'b0, w, a, d};
    @(negedge mclk) req.enable = 1;
    @(negedge mclk) req = '0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 0);
  endtask
  always @(posedge mclk)
    if (req.sel && req.enable && !req.write)
      check("prdata", q.pop_front(), prdata);
  task automatic gap(input logic r, output int k);
    {ref_go, act_go} = {r, !r};
    @(negedge mclk) {ref_go, act_go} = 2'b00;
    @(negedge mclk);
    for (k = 0; (r ? timing_ok.cmd_ok : timing_ok.pre_ok) !== 1'b1 && k < 50; k++) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  initial
  begin
    repeat (12) @(negedge mclk);
    rst = 0;
    check("pready", 1, pready);
    foreach (OFS[i]) rd(OFS[i], RST[i]);
    rd(12'h0f0, 0);
    ctrl_state = ST_LOW_POWER;
    for (int i = 1; i < 11; i++)
    begin
      s = lfsr(s);
      v[i] = s & MSK[i];
      bus(1, OFS[i], v[i]);
    end
    for (int i = 1; i < 11; i++) rd(OFS[i], v[i]);
    ctrl_state = 2'h1;
    bus(1, REFP_OFS, 32'h1234);
    rd(REFP_OFS, 0);
    rd(STATE_OFS, 1);
    check("allowed", 0, access_allowed);
    ctrl_state = ST_CONFIG;
    rd(REFP_OFS, v[1]);
    bus(1, RAS_OFS, 5);
    bus(1, RFC_OFS, 5);
    gap(0, n);
    check("pre gap", 5, n);
    gap(1, n);
    check("refresh gap", 5, n);
    autoclose_req = 1;
    for (int c = 0; c < 5; c++)
    begin
      bus(1, CFG_OFS, (c << 18) | (c << 15) | ((c & 1) << 6) | (c << 3) | c);
      s = lfsr(s);
      {read_id, col_addr} = s[23:0];
      @(negedge mclk);
      check("burst", 1 << c, cfg.burst_beats);
      check("rows", 11 + c, cfg.row_width);
      check("cols", 8 + c, cfg.col_width);
      check("ap pos", (c & 1) ? 8 : 10, cfg.autoclose_bit_position);
      check("mem_addr", col_addr | (16'h1 << ((c & 1) ? 8 : 10)), mem_addr);
      check("prio", (read_id >> c) & 8'hf, qos_prio);
    end
    // idle count 8 stays above the largest column latency, 7;
    // narrowest row and column codes keep the top address bits low
    bus(1, CFG_OFS, 32'h0020_6400);
    bus(1, REFP_OFS, 20);
    ctrl_state = 2'h1;
    for (n = 0; refresh_req === 4'h0 && n < 99; n++) @(negedge mclk);
    check("chips", 4'h3, refresh_req);
    @(negedge mclk);
    for (n = 1; refresh_req === 4'h0 && n < 99; n++) @(negedge mclk);
    check("period", 20, n);
    check("cke", 0, cke);
    check("clk_en", 0, mem_clk_en);
    busy = 1;
    repeat (2) @(negedge mclk);
    check("cke", 1, cke);
    check("clk_en", 1, mem_clk_en);
    wrap_up;
  end
endmodule // dram_config_timing_regs_tb
`default_nettype wire
